/* sri_regs.svh */
// constants of the status indicator and reset control block
// assumes a 100 MHz clock and a 1 ms timebase built from it
`ifndef SRI_REGS_SVH
`define SRI_REGS_SVH

`define SRI_OFF_CTRL 8'h00
`define SRI_OFF_PIPE_DELAY 8'h04
`define SRI_OFF_STATUS 8'h08
`define SRI_OFF_AIRFLOW 8'h0C
`define SRI_OFF_EVT_SEL 8'h10
`define SRI_OFF_EVT_DATA 8'h14
`define SRI_OFF_MENU 8'h18

`define SRI_PS1_POS 0
`define SRI_PS2_POS 4
`define SRI_PS3_POS 8
`define SRI_RST_PS1 4'h3
`define SRI_RST_PS2 4'h5
`define SRI_RST_PS3 4'h7
`define SRI_RST_PIPE_DELAY 8'h3C
`define SRI_RST_EVT_SEL 7'h01

`define SRI_CLK_PERIOD_NS 10
`define SRI_TICK_NS 1000000
`define SRI_MENU_TIMEOUT_MS 5000
`define SRI_HALF_CYCLE_MS 500
`define SRI_ONE_CYCLE_MS 1000
`define SRI_EXT_HOLD_MS 2000
`define SRI_SEC_MS 1000
`define SRI_EVT_DEPTH 99
`define SRI_MENU_POSITIONS 4'hD

`define SRI_EVT_ALARM 8'h01
`define SRI_EVT_FAULT 8'h02
`define SRI_EVT_RESET 8'h04
`define SRI_EVT_INACTIVE 8'h08

`endif

/* sri_pkg.sv */
// types of the status indicator and reset control block
// assumes sri_regs.svh supplies the numbers
package sri_pkg;

  typedef struct packed {
    logic [16:0] div;
    logic [9:0] ms;
    logic tick;
    logic sec;
    logic half_ph;
    logic one_ph;
  } sri_tb_st_t;

  typedef struct packed {
    logic [98:0][7:0] slot;
    logic [6:0] count;
  } sri_evt_st_t;

  typedef enum logic [1:0] {
    SRI_EXT_IDLE = 2'b00,
    SRI_EXT_PULSE = 2'b01,
    SRI_EXT_HELD = 2'b10
  } sri_ext_t;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [2:0] key_prev;
    sri_ext_t ext_state;
    logic [11:0] ext_ms;
    logic inactive;
    logic alarm_lat;
    logic fault_lat;
    logic [7:0] pipe_sec;
    logic menu_active;
    logic [12:0] menu_ms;
    logic [3:0] menu_pos;
    logic [11:0] presig;
    logic [7:0] pipe_delay;
    logic [6:0] evt_sel;
    logic push;
    logic [7:0] push_code;
    logic [31:0] rdata;
    logic led_op;
    logic led_alarm;
    logic led_fault;
    logic led_sensor;
    logic [9:0] led_level;
    logic fan_run;
    logic display_idle;
  } sri_st_t;

endpackage : sri_pkg

/* sri_timebase.sv */
// timebase: 1 ms tick, 1 s pulse and the two flash phases
// assumes one clock; all outputs are enables or levels on clk
`include "sri_regs.svh"
module sri_timebase #(
  parameter int TICK_CYCLES = `SRI_TICK_NS / `SRI_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic nrst,
  output logic tick,
  output logic sec,
  output logic half_ph,
  output logic one_ph
);
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [9:0] MS_LAST = 10'(`SRI_SEC_MS - 1);
  localparam logic [9:0] HALF_TGL = 10'(`SRI_HALF_CYCLE_MS / 2);

  sri_pkg::sri_tb_st_t st, next_st;

  // both phases derive from one ms counter so the cadences stay locked
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.sec = 1'b0;
    if (st.div == TICK_LAST) begin
      next_st.div = 17'h00000;
      next_st.tick = 1'b1;
      if (st.ms == MS_LAST) begin
        next_st.ms = 10'h000;
        next_st.sec = 1'b1;
      end else begin
        next_st.ms = st.ms + 10'h001;
      end
    end else begin
      next_st.div = st.div + 17'h00001;
    end
    // half cycle is a 500 ms period, so its phase repeats twice per second
    if (next_st.ms >= HALF_TGL * 10'h002) begin
      next_st.half_ph = ((next_st.ms - HALF_TGL * 10'h002) < HALF_TGL) ? 1'b1 : 1'b0;
    end else begin
      next_st.half_ph = (next_st.ms < HALF_TGL) ? 1'b1 : 1'b0;
    end
    next_st.one_ph = (next_st.ms < 10'(`SRI_ONE_CYCLE_MS / 2)) ? 1'b1 : 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
  assign sec = st.sec;
  assign half_ph = st.half_ph;
  assign one_ph = st.one_ph;
endmodule : sri_timebase

/* sri_event_mem.sv */
// event memory: newest entry always at slot 1, oldest drops out
// assumes push is a one-cycle pulse; read index 1..99, others read zero
`include "sri_regs.svh"
module sri_event_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [7:0] push_code,
  input wire logic [6:0] rd_index,
  output logic [7:0] rd_code,
  output logic [6:0] count
);
  localparam logic [6:0] DEPTH = 7'(`SRI_EVT_DEPTH);

  sri_pkg::sri_evt_st_t st, next_st;

  // shifting costs area but keeps slot 1 newest with no pointer math
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot = {st.slot[97:0], push_code};
      if (st.count != DEPTH) begin
        next_st.count = st.count + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    rd_code = 8'h00;
    if (rd_index != 7'h00 && rd_index <= DEPTH) begin
      rd_code = st.slot[rd_index - 7'h01];
    end
  end

  assign count = st.count;
endmodule : sri_event_mem

/* sri_top.sv */
// status indicator and reset control: LED cadences, event reset, menu timeout
// assumes key and panel inputs are asynchronous pins; measurement inputs are
// synchronous to clk; register port answers reads one cycle later
//
// Local design decisions: the strobed register port and the register offsets.
`include "sri_regs.svh"
module sri_top #(
  parameter int TICK_CYCLES = `SRI_TICK_NS / `SRI_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic reset_key,
  input wire logic ext_reset,
  input wire logic key_up,
  input wire logic key_ok,
  input wire logic panel_sensor_off,
  input wire logic alarm_cond,
  input wire logic pipe_fault_cond,
  input wire logic fan_tacho_missing,
  input wire logic sensor_dusty,
  input wire logic sensor_dirty,
  input wire logic sensor_faulty,
  input wire logic [3:0] smoke_level,
  input wire logic [7:0] airflow_pct,
  output logic led_op,
  output logic led_alarm,
  output logic led_fault,
  output logic led_sensor,
  output logic [9:0] led_level,
  output logic fan_run,
  output logic display_idle
);
  localparam int KEY_RST = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_OK = 2;
  localparam int EXT = 3;
  localparam int OFF = 4;
  localparam logic [11:0] EXT_HOLD = 12'(`SRI_EXT_HOLD_MS);
  localparam logic [12:0] MENU_LAST = 13'(`SRI_MENU_TIMEOUT_MS - 1);

  sri_pkg::sri_st_t st, next_st;
  logic tick;
  logic sec;
  logic half_ph;
  logic one_ph;
  logic [7:0] evt_code;
  logic [6:0] evt_count;

  sri_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .sec(sec),
    .half_ph(half_ph),
    .one_ph(one_ph)
  );

  sri_event_mem u_event_mem (
    .clk(clk),
    .nrst(nrst),
    .push(st.push),
    .push_code(st.push_code),
    .rd_index(st.evt_sel),
    .rd_code(evt_code),
    .count(evt_count)
  );

  logic [2:0] key_rise;
  logic ext_in;
  logic sensor_off;
  logic reset_req;
  logic pipe_expired;
  logic pipe_running;
  logic fault_cause;
  logic [9:0] presig_hit;

  always_comb begin
    key_rise = st.sync2[2:0] & ~st.key_prev;
    ext_in = st.sync2[EXT];
    sensor_off = st.sync2[OFF];
    pipe_expired = pipe_fault_cond && (st.pipe_sec >= st.pipe_delay);
    pipe_running = pipe_fault_cond && !pipe_expired;
    fault_cause = pipe_expired || fan_tacho_missing;
    presig_hit = 10'h000;
    // level i+1 flashes when any of the three pre-signals names it
    for (int i = 0; i < 10; i++) begin
      if (st.presig[3:0] == 4'(i + 1) || st.presig[7:4] == 4'(i + 1) ||
          st.presig[11:8] == 4'(i + 1)) begin
        presig_hit[i] = 1'b1;
      end
    end
    // a short external pulse ends while still below the hold time
    reset_req = key_rise[KEY_RST] ||
                (st.ext_state == sri_pkg::SRI_EXT_PULSE && !ext_in);
  end

  always_comb begin
    next_st = st;
    // only sync2 feeds logic; sync1 may still be settling
    next_st.sync1 = {panel_sensor_off, ext_reset, key_ok, key_up, reset_key};
    next_st.sync2 = st.sync1;
    next_st.key_prev = st.sync2[2:0];
    next_st.push = 1'b0;
    next_st.push_code = 8'h00;

    // external reset: pulse versus held level
    case (st.ext_state)
      sri_pkg::SRI_EXT_IDLE: begin
        next_st.ext_ms = 12'h000;
        if (ext_in) begin
          next_st.ext_state = sri_pkg::SRI_EXT_PULSE;
        end
      end
      sri_pkg::SRI_EXT_PULSE: begin
        if (!ext_in) begin
          next_st.ext_state = sri_pkg::SRI_EXT_IDLE;
        end else if (tick) begin
          if (st.ext_ms == EXT_HOLD - 12'h001) begin
            next_st.ext_state = sri_pkg::SRI_EXT_HELD;
            next_st.inactive = 1'b1;
            next_st.push = 1'b1;
            next_st.push_code = `SRI_EVT_INACTIVE;
          end else begin
            next_st.ext_ms = st.ext_ms + 12'h001;
          end
        end
      end
      sri_pkg::SRI_EXT_HELD: begin
        // release after the hold time switches back on and is not a reset
        if (!ext_in) begin
          next_st.ext_state = sri_pkg::SRI_EXT_IDLE;
          next_st.inactive = 1'b0;
        end
      end
      default: begin
        next_st.ext_state = sri_pkg::SRI_EXT_IDLE;
      end
    endcase

    // pipe delay counts whole seconds while the condition lasts
    // an 8-bit seconds field reaches delays past four minutes
    if (!pipe_fault_cond) begin
      next_st.pipe_sec = 8'h00;
    end else if (sec && !pipe_expired) begin
      next_st.pipe_sec = st.pipe_sec + 8'h01;
    end

    // latches: a pending cause always wins over a reset in the same cycle
    if (alarm_cond) begin
      next_st.alarm_lat = 1'b1;
    end else if (reset_req) begin
      next_st.alarm_lat = 1'b0;
    end
    if (fault_cause) begin
      next_st.fault_lat = 1'b1;
    end else if (reset_req) begin
      next_st.fault_lat = 1'b0;
    end
    // one push per cycle: a second event in the same cycle is not recorded
    if (alarm_cond && !st.alarm_lat) begin
      next_st.push = 1'b1;
      next_st.push_code = `SRI_EVT_ALARM;
    end else if (fault_cause && !st.fault_lat) begin
      next_st.push = 1'b1;
      next_st.push_code = `SRI_EVT_FAULT;
    end else if (reset_req && ((st.alarm_lat && !alarm_cond) || (st.fault_lat && !fault_cause))) begin
      next_st.push = 1'b1;
      next_st.push_code = `SRI_EVT_RESET;
    end

    // fan only stops for the inactive state, never for a reset
    next_st.fan_run = !next_st.inactive;

    // operator menu with inactivity timeout
    if (key_rise[KEY_UP] || key_rise[KEY_OK]) begin
      next_st.menu_active = 1'b1;
      next_st.menu_ms = 13'h0000;
      if (key_rise[KEY_UP] && st.menu_active) begin
        next_st.menu_pos = (st.menu_pos == `SRI_MENU_POSITIONS - 4'h1) ? 4'h0 :
                           st.menu_pos + 4'h1;
      end
    end else if (st.menu_active && tick) begin
      if (st.menu_ms == MENU_LAST) begin
        next_st.menu_active = 1'b0;
        next_st.menu_pos = 4'h0;
        next_st.menu_ms = 13'h0000;
      end else begin
        next_st.menu_ms = st.menu_ms + 13'h0001;
      end
    end
    next_st.display_idle = !next_st.menu_active;

    // LED map
    // inactive and sensor-off states mask every other indication except the operation lamp and a half_ph flash of the fault lamp
    next_st.led_op = 1'b1;
    next_st.led_alarm = 1'b0;
    next_st.led_fault = 1'b0;
    next_st.led_sensor = 1'b0;
    next_st.led_level = 10'h000;
    if (st.inactive) begin
      next_st.led_fault = half_ph;
    end else if (sensor_off) begin
      next_st.led_fault = half_ph;
    end else begin
      next_st.led_alarm = st.alarm_lat;
      if (st.fault_lat || fault_cause) begin
        next_st.led_fault = 1'b1;
      end else if (pipe_running) begin
        next_st.led_fault = one_ph;
      end
      if (sensor_faulty) begin
        next_st.led_sensor = 1'b1;
      end else if (sensor_dirty) begin
        next_st.led_sensor = half_ph;
      end else if (sensor_dusty) begin
        next_st.led_sensor = one_ph;
      end
      for (int i = 0; i < 10; i++) begin
        if (smoke_level > 4'(i)) begin
          next_st.led_level[i] = presig_hit[i] ? one_ph : 1'b1;
        end
      end
    end

    // register port: unmapped offsets read zero and ignore writes
    if (wr) begin
      case (addr)
        `SRI_OFF_CTRL: begin
          next_st.presig = wdata[11:0];
        end
        `SRI_OFF_PIPE_DELAY: begin
          next_st.pipe_delay = wdata[7:0];
        end
        `SRI_OFF_EVT_SEL: begin
          next_st.evt_sel = wdata[6:0];
        end
        default: begin
        end
      endcase
    end
    // read data stands for one cycle only and is zero otherwise
    next_st.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        `SRI_OFF_CTRL: begin
          next_st.rdata = {20'h00000, st.presig};
        end
        `SRI_OFF_PIPE_DELAY: begin
          next_st.rdata = {24'h000000, st.pipe_delay};
        end
        `SRI_OFF_STATUS: begin
          next_st.rdata = {17'h00000, evt_count, st.ext_state,
                           st.menu_active, st.fan_run, sensor_off,
                           st.inactive, st.fault_lat, st.alarm_lat};
        end
        `SRI_OFF_AIRFLOW: begin
          next_st.rdata = {24'h000000, airflow_pct};
        end
        `SRI_OFF_EVT_SEL: begin
          next_st.rdata = {25'h0000000, st.evt_sel};
        end
        `SRI_OFF_EVT_DATA: begin
          next_st.rdata = {24'h000000, evt_code};
        end
        `SRI_OFF_MENU: begin
          next_st.rdata = {28'h0000000, st.menu_pos};
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.presig <= {`SRI_RST_PS3, `SRI_RST_PS2, `SRI_RST_PS1};
      st.pipe_delay <= `SRI_RST_PIPE_DELAY;
      st.evt_sel <= `SRI_RST_EVT_SEL;
      st.ext_state <= sri_pkg::SRI_EXT_IDLE;
      st.led_op <= 1'b1;
      st.fan_run <= 1'b1;
      st.display_idle <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign led_op = st.led_op;
  assign led_alarm = st.led_alarm;
  assign led_fault = st.led_fault;
  assign led_sensor = st.led_sensor;
  assign led_level = st.led_level;
  assign fan_run = st.fan_run;
  assign display_idle = st.display_idle;
endmodule : sri_top

/* sri_top_asserts.sv */
// checker for sri_top, watching its ports only
// assumes a single clock and the async active-low nrst of the block
module sri_top_asserts #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic key_up,
  input wire logic key_ok,
  input wire logic ext_reset,
  input wire logic panel_sensor_off,
  input wire logic alarm_cond,
  input wire logic fan_tacho_missing,
  input wire logic sensor_dusty,
  input wire logic sensor_dirty,
  input wire logic sensor_faulty,
  input wire logic [3:0] smoke_level,
  input wire logic led_op,
  input wire logic led_alarm,
  input wire logic led_fault,
  input wire logic led_sensor,
  input wire logic [9:0] led_level,
  input wire logic fan_run,
  input wire logic display_idle
);
  // margin covers the pin synchronisers and the phase of the ms tick
  localparam int MENU_LIMIT = 5000 * TICK_CYCLES + 2 * TICK_CYCLES + 8;
  logic [31:0] key_age;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_age <= 32'h0;
    end else if (key_up || key_ok) begin
      key_age <= 32'h0;
    end else if (key_age != 32'hFFFFFFFF) begin
      key_age <= key_age + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  menu_timeout_a: assert property (!display_idle |-> key_age < MENU_LIMIT)
    else $error("menu left open past its timeout");
  menu_start_a: assert property ($fell(display_idle) |-> key_age < 32'h8)
    else $error("menu opened without a key");
  op_lamp_a: assert property (led_op)
    else $error("operation lamp dark");
  alarm_lamp_a: assert property (alarm_cond [*3] |-> ##[0:3] led_alarm)
    else $error("alarm lamp not lit");
  alarm_hold_a: assert property ($fell(led_alarm) |-> !$past(alarm_cond) && !$past(alarm_cond, 2))
    else $error("alarm cleared while cause present");
  tacho_fault_a: assert property ((fan_tacho_missing && fan_run && !panel_sensor_off
    && !ext_reset) [*4] |-> ##[0:3] led_fault)
    else $error("tacho loss without fault lamp");
  level_dark_a: assert property ((smoke_level == 4'h0) [*3] |-> led_level == 10'h000)
    else $error("level lamp lit without smoke");
  sensor_dark_a: assert property ((!sensor_dusty && !sensor_dirty && !sensor_faulty) [*3]
    |-> !led_sensor)
    else $error("sensor lamp lit without cause");
  sensor_steady_a: assert property ((sensor_faulty && !sensor_dusty && !sensor_dirty) [*3]
    |-> led_sensor)
    else $error("faulty sensor lamp not steady");
  fan_keep_a: assert property ($fell(fan_run) |-> $past(ext_reset) && $past(ext_reset, 4))
    else $error("fan stopped without held external reset");
  cover property ($fell(display_idle));
  cover property ($fell(fan_run));
  cover property ($fell(led_alarm));
endmodule : sri_top_asserts

bind sri_top sri_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) sri_top_asserts_i (
  .clk(clk), .nrst(nrst), .key_up(key_up), .key_ok(key_ok), .ext_reset(ext_reset),
  .panel_sensor_off(panel_sensor_off), .alarm_cond(alarm_cond),
  .fan_tacho_missing(fan_tacho_missing), .sensor_dusty(sensor_dusty),
  .sensor_dirty(sensor_dirty), .sensor_faulty(sensor_faulty), .smoke_level(smoke_level),
  .led_op(led_op), .led_alarm(led_alarm), .led_fault(led_fault), .led_sensor(led_sensor),
  .led_level(led_level), .fan_run(fan_run), .display_idle(display_idle)
);

/* sri_panel_model.sv */
// model of the upstream alarm panel and the operator keys
// assumes the bench calls its tasks; pins change just after a rising edge
module sri_panel_model (
  input wire logic clk,
  output logic reset_key,
  output logic ext_reset,
  output logic key_up,
  output logic key_ok,
  output logic panel_sensor_off
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {reset_key, ext_reset, key_up, key_ok, panel_sensor_off} = 5'h00;
  end
  // 0 reset key, 1 external reset, 2 up, 3 ok, 4 sensor off
  task drive(input int which, input logic v);
    @(posedge clk);
    case (which)
      0: reset_key <= v;
      1: ext_reset <= v;
      2: key_up <= v;
      3: key_ok <= v;
      default: panel_sensor_off <= v;
    endcase
  endtask : drive
  // a short press; a long hold of pin 1 is made with drive instead
  task press(input int which, input int n);
    drive(which, 1'b1);
    repeat (n) @(posedge clk);
    drive(which, 1'b0);
  endtask : press
endmodule : sri_panel_model

/* sri_top_tb_top.sv */
// self-checking bench of sri_top with the panel model
// assumes a shortened ms tick of TK cycles
module sri_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 2;
  localparam int WIN = 2000 * TK;
  logic clk, nrst, wr, rd, alarm_cond, pipe_fault_cond, fan_tacho_missing;
  logic reset_key, ext_reset, key_up, key_ok, panel_sensor_off;
  logic sensor_dusty, sensor_dirty, sensor_faulty, led_op, led_alarm, led_fault, led_sensor;
  logic fan_run, display_idle;
  logic [3:0] smoke_level;
  logic [7:0] addr, airflow_pct;
  logic [9:0] led_level;
  logic [31:0] wdata, rdata;
  int mismatches, tests_run;
  sri_top #(.TICK_CYCLES(TK)) sri_top_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .reset_key(reset_key), .ext_reset(ext_reset), .key_up(key_up), .key_ok(key_ok),
    .panel_sensor_off(panel_sensor_off), .alarm_cond(alarm_cond),
    .pipe_fault_cond(pipe_fault_cond), .fan_tacho_missing(fan_tacho_missing),
    .sensor_dusty(sensor_dusty), .sensor_dirty(sensor_dirty), .sensor_faulty(sensor_faulty),
    .smoke_level(smoke_level), .airflow_pct(airflow_pct), .led_op(led_op),
    .led_alarm(led_alarm), .led_fault(led_fault), .led_sensor(led_sensor),
    .led_level(led_level), .fan_run(fan_run), .display_idle(display_idle));
  sri_panel_model sri_panel_model_i (.clk(clk), .reset_key(reset_key),
    .ext_reset(ext_reset), .key_up(key_up), .key_ok(key_ok),
    .panel_sensor_off(panel_sensor_off));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(what, rdata, exp);
  endtask : rchk
  function automatic logic pick(input int w);
    if (w == 0) return led_fault;
    if (w == 1) return led_sensor;
    return led_level[w-2];
  endfunction : pick
  // 0 dark, 1 steady, 2 one-second flash, 3 half-second flash, 4 other
  task cad(input int w, input logic [31:0] exp, input string what);
    int t;
    logic p, s;
    t = 0;
    // let synchronisers and the output register settle first
    repeat (8) @(negedge clk);
    p = pick(w);
    s = p;
    repeat (WIN) begin
      @(negedge clk);
      s = pick(w);
      if (s !== p) t++;
      p = s;
    end
    chk(what, (t == 0) ? {31'h0, s} : (t >= 3 && t <= 5) ? 32'h2 :
      (t >= 7 && t <= 9) ? 32'h3 : 32'h4, exp);
    @(posedge clk);
  endtask : cad
  task t_regs();
    chk("idle lamps", {led_op, led_alarm, led_fault, led_sensor, led_level}, 32'h2000);
    rchk(8'h00, 32'h753, "presignal map");
    rchk(8'h04, 32'h3C, "pipe delay");
    rchk(8'h10, 32'h1, "event select");
    rchk(8'h0C, 32'hFF, "airflow");
    wreg(8'h40, 32'hFFFF);
    rchk(8'h40, 32'h0, "unmapped");
  endtask : t_regs
  task t_alarm();
    @(posedge clk);
    alarm_cond <= 1'b1;
    repeat (10) @(posedge clk);
    chk("alarm lamps", {led_op, led_alarm, led_fault}, 32'h6);
    sri_panel_model_i.press(0, 20);
    repeat (10) @(posedge clk);
    chk("alarm kept", led_alarm, 32'h1);
    alarm_cond <= 1'b0;
    sri_panel_model_i.press(0, 20);
    repeat (10) @(posedge clk);
    chk("alarm cleared", {led_alarm, fan_run}, 32'h1);
    rchk(8'h08, 32'h210, "status after clear");
    rchk(8'h14, 32'h04, "newest event");
    wreg(8'h10, 32'h2);
    rchk(8'h14, 32'h01, "second event");
  endtask : t_alarm
  task t_faults();
    @(posedge clk);
    fan_tacho_missing <= 1'b1;
    cad(0, 32'h1, "tacho fault");
    fan_tacho_missing <= 1'b0;
    sri_panel_model_i.press(1, 40);
    repeat (10) @(posedge clk);
    chk("fault by ext pulse", led_fault, 32'h0);
    sri_panel_model_i.drive(1, 1'b1);
    repeat (2000 * TK + 100) @(posedge clk);
    cad(0, 32'h3, "inactive fault");
    chk("inactive op fan", {led_op, fan_run}, 32'h2);
    sri_panel_model_i.drive(1, 1'b0);
    sri_panel_model_i.drive(4, 1'b1);
    repeat (20) @(posedge clk);
    chk("fan back", fan_run, 32'h1);
    cad(0, 32'h3, "sensor off fault");
    chk("sensor off op", led_op, 32'h1);
    sri_panel_model_i.drive(4, 1'b0);
    wreg(8'h04, 32'h3);
    pipe_fault_cond <= 1'b1;
    cad(0, 32'h2, "pipe delay running");
    repeat (1200 * TK) @(posedge clk);
    cad(0, 32'h1, "pipe fault triggered");
    pipe_fault_cond <= 1'b0;
  endtask : t_faults
  task t_levels();
    @(posedge clk);
    smoke_level <= 4'h4;
    cad(2, 32'h1, "level one");
    cad(4, 32'h2, "level three");
    wreg(8'h00, 32'h751);
    cad(2, 32'h2, "level one moved");
    cad(5, 32'h1, "level four");
    smoke_level <= 4'h0;
  endtask : t_levels
  task t_sensor();
    logic [31:0] want;
    for (int k = 0; k < 3; k++) begin
      // dusty, then dirty, then faulty
      want = (k == 0) ? 32'h2 : (k == 1) ? 32'h3 : 32'h1;
      @(posedge clk);
      {sensor_dusty, sensor_dirty, sensor_faulty} <= 3'h4 >> k;
      cad(1, want, "sensor lamp");
    end
    {sensor_dusty, sensor_dirty, sensor_faulty} <= 3'h0;
  endtask : t_sensor
  task t_menu();
    sri_panel_model_i.press(2, 20);
    sri_panel_model_i.press(2, 20);
    sri_panel_model_i.press(3, 20);
    rchk(8'h18, 32'h1, "menu position");
    repeat (5000 * TK - 200) @(posedge clk);
    chk("menu open", display_idle, 32'h0);
    repeat (400) @(posedge clk);
    chk("menu dropped", display_idle, 32'h1);
    rchk(8'h18, 32'h0, "menu position cleared");
  endtask : t_menu
  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    airflow_pct = 8'hFF;
    smoke_level = 4'h0;
    {wr, rd, alarm_cond, pipe_fault_cond, fan_tacho_missing} = 5'h00;
    {sensor_dusty, sensor_dirty, sensor_faulty} = 3'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_alarm();
    t_faults();
    t_levels();
    t_sensor();
    t_menu();
    summarize();
  end
  // the scenarios need about 66000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : sri_top_tb_top
